// *** hdl/tcq_params.svh ***
// Constants of the trace capture qualifier: offsets, fields, resets.
// Assumes inclusion by bare name from each design file.
`ifndef TCQ_PARAMS_SVH
`define TCQ_PARAMS_SVH

// ----------------------------------------------------------------
// Host I/O decode
// ----------------------------------------------------------------
`define TRACE_BASE_DEFAULT 10'h208
`define IO_BLOCK_SIZE 10'h010
`define JUMPER_SETTLE 2'h2

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_REPEAT 8'h08
`define REG_POST 8'h0C
`define REG_IRQ_STAT 8'h10
`define REG_IRQ_MASK 8'h14
`define COND_BLOCK 2'h1
`define COND_ADDR_LO 2'h0
`define COND_ADDR_HI 2'h1
`define COND_DATA 2'h2
`define COND_MODE 2'h3

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define CTRL_FILT_EN 3
`define CTRL_INH_EN 4
`define CTRL_ONCE 5
`define CTRL_ARM 6
`define CTRL_STORE_MASK 8'h3F
`define IRQ_TRIG 0
`define IRQ_STOP 1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CTRL_RST 8'h00
`define REPEAT_RST 16'h0001
`define POST_RST 16'h0000
`define ADDR_LO_RST 24'h000000
`define ADDR_HI_RST 24'hFFFFFF
`define DATA_LO_RST 16'h0000
`define DATA_HI_RST 16'hFFFF
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** hdl/tcq_pkg.sv ***
// Types shared by the trace capture qualifier modules.
// Assumes nothing beyond a SystemVerilog compiler.
package tcq_pkg;

  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] data;
    logic fetch;
    logic write;
    logic [7:0] ext;
    logic trig_in;
  } frame_t;

  typedef enum logic [1:0] {
    CYC_ALL = 2'h0,
    CYC_FETCH = 2'h1,
    CYC_DATA = 2'h2,
    CYC_NONE = 2'h3
  } cyc_mode_t;

  typedef struct packed {
    logic [23:0] addr_lo;
    logic [23:0] addr_hi;
    logic [15:0] data_lo;
    logic [15:0] data_hi;
    logic pattern;
    cyc_mode_t cyc;
  } cond_cfg_t;

  typedef enum logic [1:0] {
    ST_ARMED = 2'h0,
    ST_POST = 2'h1,
    ST_DONE = 2'h3
  } rec_state_t;

  typedef struct packed {
    logic [6:0] j1;
    logic [6:0] j2;
    logic [9:0] a1;
    logic [9:0] a2;
    logic st1;
    logic st2;
    logic [1:0] settle;
    logic [9:0] base;
    logic sel;
    logic [3:0] off;
  } isa_state_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } axi_state_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [15:0] rep;
    logic [15:0] post;
    logic [1:0] imask;
    cond_cfg_t [3:0] cond;
  } cfg_t;

  typedef struct packed {
    logic c1;
    logic c2;
    logic c3;
    frame_t f1;
    frame_t f2;
    logic x1;
    logic x2;
    cfg_t cfg;
    axi_state_t axi;
    logic [1:0] istat;
    logic irq;
    rec_state_t rst;
    logic [15:0] hits;
    logic [15:0] pcnt;
    logic released;
    logic fired_once;
    logic fvalid;
    frame_t fout;
    logic tout;
  } tq_state_t;

endpackage

// *** hdl/cond_match.sv ***
// One condition set: cycle type, address range and data range.
// Assumes a frame that is stable for the cycle it is compared in.
`timescale 1ns/1ps
`include "tcq_params.svh"

module cond_match import tcq_pkg::*; (
  // Compared frame
  input frame_t frame,
  // Condition settings
  input cond_cfg_t cfg,
  // Result
  output logic met
);

  logic type_ok;
  logic addr_ok;
  logic data_ok;

  always_comb begin
    case (cfg.cyc)
      CYC_ALL: type_ok = 1'b1;
      CYC_FETCH: type_ok = frame.fetch;
      CYC_DATA: type_ok = ~frame.fetch;
      CYC_NONE: type_ok = 1'b0;
      default: type_ok = 1'b0;
    endcase
  end

  // Address with cycle type, and data, each a boolean result
  assign addr_ok = type_ok && (frame.addr >= cfg.addr_lo) &&
                   (frame.addr <= cfg.addr_hi);
  assign data_ok = cfg.pattern ? (frame.data == cfg.data_lo) :
                   ((frame.data >= cfg.data_lo) &&
                    (frame.data <= cfg.data_hi));
  assign met = addr_ok && data_ok;

endmodule

// *** hdl/isa_decode.sv ***
// Host I/O address decode against the jumper-set base.
// Assumes host strobes and jumpers are asynchronous pins.
`timescale 1ns/1ps
`include "tcq_params.svh"

module isa_decode import tcq_pkg::*; (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Host pins
  input wire logic [9:0] isa_addr,
  input wire logic isa_ior_n,
  input wire logic isa_iow_n,
  input wire logic [6:0] base_address_jumper_header,
  // Decode result
  output logic io_select,
  output logic [3:0] io_offset
);

  isa_state_t s;
  isa_state_t next_s;
  logic [9:0] diff;

  assign diff = s.a2 - s.base;

  always_comb begin
    next_s = s;
    next_s.j1 = base_address_jumper_header;
    next_s.j2 = s.j1;
    next_s.a1 = isa_addr;
    next_s.a2 = s.a1;
    next_s.st1 = ~isa_ior_n | ~isa_iow_n;
    next_s.st2 = s.st1;
    if (s.settle != `JUMPER_SETTLE) begin
      next_s.settle = s.settle + 2'h1;
    end
    // Pins A9..A3 only; shorted pair reads as a zero bit
    if (s.settle == `JUMPER_SETTLE) begin
      next_s.base = {~s.j2, 3'h0};
    end
    next_s.sel = s.st2 && (diff < `IO_BLOCK_SIZE);
    if (next_s.sel) begin
      next_s.off = diff[3:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.base <= `TRACE_BASE_DEFAULT;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign io_select = s.sel;
  assign io_offset = s.off;

  a_block_miss: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && s.st2 && (diff >= `IO_BLOCK_SIZE) |=> !io_select)
    else $error("select raised outside the 16-address block");

  a_block_hit: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && s.st2 && (diff < `IO_BLOCK_SIZE) |=>
    io_select && (io_offset == $past(diff[3:0])))
    else $error("address inside the block not selected");

endmodule

// *** hdl/trace_capture_qualifier.sv ***
// Trace capture qualifier: frame capture, trigger and filter logic.
// Assumes target strobe and frame pins are asynchronous to aclk and
// the frame is stable for two aclk periods around each strobe edge.
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`include "tcq_params.svh"

module trace_capture_qualifier import tcq_pkg::*; (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Host I/O pins
  input wire logic [9:0] isa_addr,
  input wire logic isa_ior_n,
  input wire logic isa_iow_n,
  input wire logic [6:0] base_address_jumper_header,
  output logic io_select,
  output logic [3:0] io_offset,
  // Target bus cycle
  input wire logic tgt_cycle,
  input wire logic [23:0] tgt_addr,
  input wire logic [15:0] tgt_data,
  input wire logic tgt_fetch,
  input wire logic tgt_write,
  input wire logic [7:0] ext_in,
  // Trigger lines
  input wire logic trig_in,
  input wire logic ext_trig_n,
  output logic trig_out,
  // Recorded frames and interrupt
  output logic frame_valid,
  output frame_t frame_out,
  output logic irq
);

  localparam cond_cfg_t COND_RST = '{
    addr_lo: `ADDR_LO_RST,
    addr_hi: `ADDR_HI_RST,
    data_lo: `DATA_LO_RST,
    data_hi: `DATA_HI_RST,
    pattern: 1'b0,
    cyc: CYC_ALL
  };

  tq_state_t s;
  tq_state_t next_s;
  logic [3:0] met;
  logic cyc_edge;
  logic inhibit;
  logic top_hit;
  logic qual;
  logic fire;
  logic rec;
  logic [16:0] hits_inc;
  logic [15:0] pcnt_inc;
  logic wr_go;
  logic arm;

  // ----------------------------------------------------------------
  // Host I/O decode
  // ----------------------------------------------------------------
  isa_decode u_isa (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .isa_addr(isa_addr),
    .isa_ior_n(isa_ior_n),
    .isa_iow_n(isa_iow_n),
    .base_address_jumper_header(base_address_jumper_header),
    .io_select(io_select),
    .io_offset(io_offset)
  );

  // ----------------------------------------------------------------
  // Condition sets: 0..2 triggers, 3 filter
  // ----------------------------------------------------------------
  genvar gi;
  for (gi = 0; gi < 4; gi++) begin : g_cond
    cond_match u_cond (
      .frame(s.f2),
      .cfg(s.cfg.cond[gi]),
      .met(met[gi])
    );
  end

  // ----------------------------------------------------------------
  // Register access helpers
  // ----------------------------------------------------------------
  function automatic logic [32:0] rd_word(input logic [7:0] a);
    cond_cfg_t c;
    c = s.cfg.cond[a[5:4]];
    rd_word = {1'b1, 32'h00000000};
    if (a[7:6] == `COND_BLOCK) begin
      case (a[3:2])
        `COND_ADDR_LO: rd_word[31:0] = {8'h00, c.addr_lo};
        `COND_ADDR_HI: rd_word[31:0] = {8'h00, c.addr_hi};
        `COND_DATA: rd_word[31:0] = {c.data_hi, c.data_lo};
        `COND_MODE: rd_word[31:0] = {29'h0, c.pattern, c.cyc};
        default: rd_word[32] = 1'b0;
      endcase
    end else begin
      case (a)
        `REG_CTRL: rd_word[31:0] = {24'h0, s.cfg.ctrl};
        `REG_STATUS: rd_word[31:0] = {s.pcnt, 12'h0, s.released,
                                      s.fired_once, s.rst};
        `REG_REPEAT: rd_word[31:0] = {16'h0, s.cfg.rep};
        `REG_POST: rd_word[31:0] = {16'h0, s.cfg.post};
        `REG_IRQ_STAT: rd_word[31:0] = {30'h0, s.istat};
        `REG_IRQ_MASK: rd_word[31:0] = {30'h0, s.cfg.imask};
        default: rd_word[32] = 1'b0;
      endcase
    end
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] d,
                                        input logic [3:0] b);
    for (int k = 0; k < 4; k++) begin
      merge[8*k +: 8] = b[k] ? d[8*k +: 8] : o[8*k +: 8];
    end
  endfunction

  // ----------------------------------------------------------------
  // Trigger qualification
  // ----------------------------------------------------------------
  assign cyc_edge = s.c2 & ~s.c3;
  assign inhibit = s.cfg.ctrl[`CTRL_INH_EN] & ~s.released;
  assign top_hit = s.cfg.ctrl[2] ? met[2] :
                   s.cfg.ctrl[1] ? met[1] :
                   s.cfg.ctrl[0] ? met[0] : 1'b0;
  assign qual = cyc_edge & top_hit & ~inhibit & (s.rst != ST_DONE);
  assign hits_inc = {1'b0, s.hits} + 17'h00001;
  assign fire = qual & (hits_inc >= {1'b0, s.cfg.rep});
  assign rec = cyc_edge & (s.rst != ST_DONE) &
               (~s.cfg.ctrl[`CTRL_FILT_EN] | met[3]);
  assign pcnt_inc = s.pcnt + 16'h0001;
  assign wr_go = s.axi.awready;
  assign arm = wr_go && (awaddr == `REG_CTRL) && wstrb[0] &&
               wdata[`CTRL_ARM];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [32:0] cur;
    logic [31:0] w;
    logic [1:0] iset;
    logic [1:0] iclr;
    cond_cfg_t c;
    next_s = s;
    iset = 2'h0;
    iclr = 2'h0;
    cur = rd_word(awaddr);
    w = merge(cur[31:0], wdata, wstrb);
    c = s.cfg.cond[awaddr[5:4]];

    // Pin synchronisers
    next_s.c1 = tgt_cycle;
    next_s.c2 = s.c1;
    next_s.c3 = s.c2;
    next_s.f1 = {tgt_addr, tgt_data, tgt_fetch, tgt_write, ext_in,
                 trig_in};
    next_s.f2 = s.f1;
    next_s.x1 = ext_trig_n;
    next_s.x2 = s.x1;

    // Write channel: both taken on the awready cycle
    if (!s.axi.awready && !s.axi.bvalid && awvalid && wvalid) begin
      next_s.axi.awready = 1'b1;
      next_s.axi.wready = 1'b1;
    end
    if (s.axi.bvalid && bready) begin
      next_s.axi.bvalid = 1'b0;
    end
    if (wr_go) begin
      next_s.axi.awready = 1'b0;
      next_s.axi.wready = 1'b0;
      next_s.axi.bvalid = 1'b1;
      next_s.axi.bresp = cur[32] ? `RESP_OKAY : `RESP_SLVERR;
      if (awaddr[7:6] == `COND_BLOCK) begin
        case (awaddr[3:2])
          `COND_ADDR_LO: c.addr_lo = w[23:0];
          `COND_ADDR_HI: c.addr_hi = w[23:0];
          `COND_DATA: c.data_lo = w[15:0];
          `COND_MODE: c.pattern = w[2];
          default: c.cyc = CYC_ALL;
        endcase
        if (awaddr[3:2] == `COND_DATA) begin
          c.data_hi = w[31:16];
        end
        if (awaddr[3:2] == `COND_MODE) begin
          c.cyc = cyc_mode_t'(w[1:0]);
        end
        next_s.cfg.cond[awaddr[5:4]] = c;
      end else begin
        case (awaddr)
          `REG_CTRL: next_s.cfg.ctrl = w[7:0] & `CTRL_STORE_MASK;
          `REG_REPEAT: next_s.cfg.rep = w[15:0];
          `REG_POST: next_s.cfg.post = w[15:0];
          `REG_IRQ_STAT: iclr = wstrb[0] ? wdata[1:0] : 2'h0;
          `REG_IRQ_MASK: next_s.cfg.imask = w[1:0];
          default: next_s.axi.bresp = `RESP_SLVERR;
        endcase
      end
    end

    // Read channel
    if (!s.axi.arready && !s.axi.rvalid && arvalid) begin
      next_s.axi.arready = 1'b1;
    end
    if (s.axi.rvalid && rready) begin
      next_s.axi.rvalid = 1'b0;
    end
    if (s.axi.arready) begin
      cur = rd_word(araddr);
      next_s.axi.arready = 1'b0;
      next_s.axi.rvalid = 1'b1;
      next_s.axi.rdata = cur[31:0];
      next_s.axi.rresp = cur[32] ? `RESP_OKAY : `RESP_SLVERR;
    end

    // Trigger, recording and post-trigger count
    next_s.released = s.released | s.x2;
    next_s.tout = 1'b0;
    next_s.fvalid = rec;
    if (rec) begin
      next_s.fout = s.f2;
    end
    if (qual) begin
      next_s.hits = fire ? 16'h0000 : hits_inc[15:0];
    end
    if (fire) begin
      next_s.tout = ~(s.cfg.ctrl[`CTRL_ONCE] & s.fired_once);
      next_s.fired_once = 1'b1;
      iset[`IRQ_TRIG] = 1'b1;
      if (s.rst == ST_ARMED) begin
        next_s.pcnt = 16'h0000;
        if (s.cfg.post == 16'h0000) begin
          next_s.rst = ST_DONE;
          iset[`IRQ_STOP] = 1'b1;
        end else begin
          next_s.rst = ST_POST;
        end
      end
    end
    if ((s.rst == ST_POST) && rec) begin
      next_s.pcnt = pcnt_inc;
      if (pcnt_inc == s.cfg.post) begin
        next_s.rst = ST_DONE;
        iset[`IRQ_STOP] = 1'b1;
      end
    end
    if (arm) begin
      next_s.rst = ST_ARMED;
      next_s.hits = 16'h0000;
      next_s.pcnt = 16'h0000;
      next_s.released = 1'b0;
      next_s.fired_once = 1'b0;
    end

    // Sticky events; a new event beats a same-cycle clear
    next_s.istat = (s.istat & ~iclr) | iset;
    next_s.irq = |(next_s.istat & next_s.cfg.imask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.cfg.ctrl <= `CTRL_RST;
      s.cfg.rep <= `REPEAT_RST;
      s.cfg.post <= `POST_RST;
      s.cfg.cond <= {4{COND_RST}};
    end else if (ce) begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign awready = s.axi.awready;
  assign wready = s.axi.wready;
  assign bvalid = s.axi.bvalid;
  assign bresp = s.axi.bresp;
  assign arready = s.axi.arready;
  assign rvalid = s.axi.rvalid;
  assign rdata = s.axi.rdata;
  assign rresp = s.axi.rresp;
  assign trig_out = s.tout;
  assign frame_valid = s.fvalid;
  assign frame_out = s.fout;
  assign irq = s.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_all_frames: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && cyc_edge && (s.rst != ST_DONE) &&
    !s.cfg.ctrl[`CTRL_FILT_EN] |=>
    frame_valid && (frame_out == $past(s.f2)))
    else $error("unfiltered bus cycle not recorded");

  a_filter_gate: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && cyc_edge && s.cfg.ctrl[`CTRL_FILT_EN] && !met[3] |=>
    !frame_valid)
    else $error("frame recorded with filter not met");

  a_default_quiet: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && (s.cfg.ctrl[2:0] == 3'h0) |=> !trig_out)
    else $error("trigger with no trigger set enabled");

  a_inhibit_low: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && s.cfg.ctrl[`CTRL_INH_EN] && !s.released |=> !trig_out)
    else $error("trigger while external inhibit holds");

  a_pulse_width: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && trig_out |=> !trig_out)
    else $error("trigger output wider than one cycle");

  a_once_only: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && s.cfg.ctrl[`CTRL_ONCE] && s.fired_once |=> !trig_out)
    else $error("second pulse in pulse-once mode");

  a_repeat_wait: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && qual && !arm && (hits_inc < {1'b0, s.cfg.rep}) |=>
    !trig_out && (s.hits == $past(hits_inc[15:0])))
    else $error("trigger before repeat count reached");

  a_post_stop: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && (s.rst == ST_POST) && rec && (pcnt_inc == s.cfg.post) &&
    !arm |=> (s.rst == ST_DONE) ##1 !frame_valid)
    else $error("recording did not stop after post count");

  a_write_resp: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && wr_go |=> bvalid && !awready)
    else $error("write taken without response");

endmodule

// *** testbench/isa_host_model.sv ***
// Host side of the I/O decode: drives address and strobes.
// Assumes one host access at a time, requested by the bench.
`timescale 1ns/1ps
module isa_host_model (
  // Clock
  input wire logic aclk,
  // Request from bench
  input wire logic go,
  input wire logic wr,
  input wire logic [9:0] addr,
  // Host pins
  output logic [9:0] isa_addr,
  output logic isa_ior_n,
  output logic isa_iow_n
);
  initial begin
    isa_addr = 10'h000;
    isa_ior_n = 1'b1;
    isa_iow_n = 1'b1;
  end
  // Released address lines toggle, never hold the last value
  always @(posedge aclk) begin
    isa_addr <= go ? addr : ~isa_addr;
    isa_ior_n <= ~(go & ~wr);
    isa_iow_n <= ~(go & wr);
  end
endmodule

// *** testbench/trace_capture_qualifier_bench.sv ***
// Self-checking bench of the trace capture qualifier.
// Assumes the host model beside it; ce and write strobes stay high.
`timescale 1ns/1ps
module trace_capture_qualifier_bench import tcq_pkg::*; ;
  logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, io_offset;
  logic awready, wready, bvalid, arready, rvalid, io_select;
  logic trig_out, frame_valid, irq, isa_ior_n, isa_iow_n, h_go, h_wr;
  logic [1:0] bresp, rresp;
  frame_t frame_out;
  logic [9:0] isa_addr, h_addr;
  logic [6:0] base_address_jumper_header;
  logic tgt_cycle, tgt_fetch, tgt_write, trig_in, ext_trig_n;
  logic [23:0] tgt_addr;
  logic [15:0] tgt_data;
  logic [7:0] ext_in;
  int fails, checks_done, lo, hi, dlo, dhi, rep, post, st, hits, pl, pd;
  bit en, once, inh, rel, fo, flt;
  // Jumpers, host address, select, offset
  logic [21:0] tv [8] = '{{7'h3E, 10'h20D, 5'h15}, {7'h3E, 10'h207, 5'h00},
    {7'h3E, 10'h217, 5'h1F}, {7'h3E, 10'h218, 5'h00},
    {7'h3C, 10'h218, 5'h10}, {7'h3C, 10'h210, 5'h00},
    {7'h00, 10'h3F8, 5'h10}, {7'h7F, 10'h00F, 5'h1F}};

  trace_capture_qualifier i_trace_capture_qualifier (.aclk, .aresetn, .ce,
    .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid,
    .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
    .rresp, .isa_addr, .isa_ior_n, .isa_iow_n, .base_address_jumper_header,
    .io_select, .io_offset, .tgt_cycle, .tgt_addr, .tgt_data, .tgt_fetch,
    .tgt_write, .ext_in, .trig_in, .ext_trig_n, .trig_out, .frame_valid,
    .frame_out, .irq);
  isa_host_model i_isa_host_model (.aclk, .go(h_go), .wr(h_wr),
    .addr(h_addr), .isa_addr, .isa_ior_n, .isa_iow_n);

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [63:0] x,
                     input logic [63:0] g);
    checks_done++;
    if (g !== x) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    chk("bresp", er, bresp);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic [1:0] er);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    chk("rdata", x, rdata);
    chk("rresp", er, rresp);
  endtask

  // One target cycle; the model decides record and trigger
  task automatic frame(input logic [23:0] a, input logic [15:0] d);
    logic [3:0] nv, nt;
    logic [7:0] e;
    logic f, w, ti, met, rec, fire, tx;
    e = 8'($urandom);
    ti = 1'($urandom);
    f = 1'($urandom);
    w = 1'($urandom);
    met = en && a >= lo && a <= hi && d >= dlo && d <= dhi && !(inh && !rel);
    rec = st != 3 && (!flt || (f && d == pd));
    fire = 1'b0;
    if (st != 3 && met) begin
      hits++;
      if (hits >= rep) begin
        hits = 0;
        fire = 1'b1;
      end
    end
    tx = fire && !(once && fo);
    fo |= fire;
    if (st == 1 && rec) begin
      pl--;
      if (pl == 0) st = 3;
    end else if (fire && st == 0) begin
      pl = post;
      st = post == 0 ? 3 : 1;
    end
    nv = 4'h0;
    nt = 4'h0;
    @(posedge aclk);
    tgt_addr <= a;
    tgt_data <= d;
    ext_in <= e;
    trig_in <= ti;
    tgt_fetch <= f;
    tgt_write <= w;
    tgt_cycle <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge aclk);
      if (i == 3) tgt_cycle <= 1'b0;
      #1 nv += frame_valid;
      nt += trig_out;
    end
    chk("frame_valid", rec, nv);
    chk("trig_out", tx, nt);
    if (rec) chk("frame_out", {a, d, f, w, e, ti}, frame_out);
  endtask

  task automatic tdone(input string n);
    $display("test %s done", n);
  endtask

  task give_verdict;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, tgt_cycle, h_go, h_wr} = '0;
    {awaddr, araddr, wdata, tgt_addr, tgt_data, ext_in, h_addr} = '0;
    {tgt_fetch, tgt_write, trig_in, ext_trig_n, aresetn} = '0;
    ce = 1'b1;
    wstrb = 4'hF;
    base_address_jumper_header = 7'h3E;
    {fails, checks_done, lo, dlo, st, hits, pl, post} = '0;
    hi = 'hFFFFFF;
    dhi = 'hFFFF;
    rep = 1;
    void'($urandom(12545));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, 32'h0, 2'h0);
    rd(8'h08, 32'h1, 2'h0);
    rd(8'h64, 32'hFFFFFF, 2'h0);
    rd(8'h68, 32'hFFFF0000, 2'h0);
    rd(8'h20, 32'h0, 2'h2);
    wr(8'h20, 32'h5, 2'h2);
    tdone("registers");
    foreach (tv[k]) begin
      @(posedge aclk);
      base_address_jumper_header <= tv[k][21:15];
      h_go <= 1'b0;
      repeat (6) @(posedge aclk);
      h_addr <= tv[k][14:5];
      h_wr <= k[0];
      h_go <= 1'b1;
      repeat (6) @(posedge aclk);
      #1 chk("io_select", tv[k][4], io_select);
      if (tv[k][4]) chk("io_offset", tv[k][3:0], io_offset);
    end
    @(posedge aclk);
    h_go <= 1'b0;
    tdone("decode");
    repeat (4) frame(24'($urandom), 16'($urandom));
    tdone("default");
    wr(8'h60, 32'h1000, 2'h0);
    wr(8'h64, 32'h10FF, 2'h0);
    wr(8'h0C, 32'h3, 2'h0);
    wr(8'h00, 32'h24, 2'h0);
    {lo, hi, post, en, once} = {32'h1000, 32'h10FF, 32'd3, 2'b11};
    frame(24'h1080, 16'h1);
    frame(24'h10FF, 16'h2);
    frame(24'h0FFF, 16'h3);
    frame(24'h1100, 16'h4);
    frame(24'h1000, 16'h5);
    tdone("pulse once");
    wr(8'h10, 32'h3, 2'h0);
    wr(8'h14, 32'h1, 2'h0);
    wr(8'h68, 32'h00200010, 2'h0);
    wr(8'h08, 32'h2, 2'h0);
    wr(8'h0C, 32'h0, 2'h0);
    wr(8'h00, 32'h44, 2'h0);
    rd(8'h00, 32'h04, 2'h0);
    {once, dlo, dhi, rep} = {1'b0, 32'h10, 32'h20, 32'd2};
    {post, st, hits} = 96'd0;
    #1 chk("irq", 1'b0, irq);
    frame(24'h1010, 16'h30);
    frame(24'h1010, 16'h0F);
    frame(24'h1010, 16'h10);
    frame(24'h1010, 16'h20);
    repeat (2) @(posedge aclk);
    #1 chk("irq", 1'b1, irq);
    wr(8'h10, 32'h1, 2'h0);
    repeat (2) @(posedge aclk);
    #1 chk("irq", 1'b0, irq);
    tdone("repeat and irq");
    wr(8'h08, 32'h1, 2'h0);
    wr(8'h00, 32'h54, 2'h0);
    {rep, inh, st, hits, rel} = {32'd1, 1'b1, 64'd0, 1'b0};
    frame(24'h1020, 16'h15);
    @(posedge aclk);
    ext_trig_n <= 1'b1;
    repeat (4) @(posedge aclk);
    ext_trig_n <= 1'b0;
    rel = 1'b1;
    frame(24'h1020, 16'h15);
    tdone("inhibit");
    // Filter set: opcode fetch only, data pattern 42H
    wr(8'h7C, 32'h5, 2'h0);
    wr(8'h78, 32'h42, 2'h0);
    wr(8'h00, 32'h48, 2'h0);
    {en, flt, st, pd} = {1'b0, 1'b1, 64'h42};
    frame(24'h2000, 16'h42);
    frame(24'h2000, 16'h42);
    frame(24'h2000, 16'h43);
    tdone("filter");
    give_verdict;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    give_verdict;
  end
endmodule
